// file: logic/pmcd_cfg.svh
// constants for the power-manager command decoder
// assumes inclusion by bare name before any use of the macros
`ifndef PMCD_CFG_SVH
`define PMCD_CFG_SVH

// link address: six fixed bits, then strap bit, then write bit
`define PMCD_ADDR_FIXED       6'h33
`define PMCD_ADDR_DEFAULT_BIT 1'h0
`define PMCD_WRITE_BIT        1'h0

// register byte offsets on the bus, then the control register reset value
`define PMCD_REG_CTRL    4'h0
`define PMCD_REG_OFFSET  4'h4
`define PMCD_REG_SETTING 4'h8
`define PMCD_REG_STATUS  4'hC
`define PMCD_CTRL_RST    1'h1

// command byte fields (byte bit 7 is first on the wire)
`define PMCD_CMD_OS_BIT  4
`define PMCD_CMD_MAIN    3
`define PMCD_CMD_BRIDGE  2
`define PMCD_CMD_OV      3'h0
`define PMCD_CMD_FSW     3'h1
`define PMCD_CMD_SLOPE   3'h2
`define PMCD_CMD_FLAGS   3'h3

// data byte fields
`define PMCD_D_SIGN      5
`define PMCD_D_PHASE     2
`define PMCD_D_HINT_EN   1
`define PMCD_D_SHED_EN   0

// offset scaling and limits
`define PMCD_OS_STEP_MV    13'h0032
`define PMCD_CORE_MAX_MV   13'h0AF0
`define PMCD_BRIDGE_MAX_MV 13'h0258

// reset values and skipped codes
`define PMCD_OV_RST       2'h0
`define PMCD_FSW_RST      3'h0
`define PMCD_SLOPE_RST    2'h0
`define PMCD_SLOPE_SKIP   2'h2
`define PMCD_FSW_SKIP     2'h3
`define PMCD_SHED_TH_RST  2'h0
`define PMCD_PHASE_RST    1'h0
`define PMCD_HINT_EN_RST  1'h1
`define PMCD_SHED_EN_RST  1'h0

`endif

// file: logic/pmcd_pkg.sv
// types for the power-manager command decoder
// assumes nothing of its surroundings
package pmcd_pkg;

  typedef enum logic [7:0] {
    PMCD_IDLE     = 8'h01,
    PMCD_ADDR     = 8'h02,
    PMCD_ADDR_ACK = 8'h04,
    PMCD_CMD      = 8'h08,
    PMCD_CMD_ACK  = 8'h10,
    PMCD_DATA     = 8'h20,
    PMCD_DATA_ACK = 8'h40,
    PMCD_WAIT     = 8'h80
  } pmcd_state_t;

endpackage

// file: logic/pmcd_decoder.sv
// power-manager serial write port: address, command, data, then apply
// assumes Avalon-MM master on clock; link pins asynchronous to clock
//
// Function
// - answer address 110011 plus strap bit; strap picks seventh bit
// - strap at default makes the seventh address bit zero
// - command bit 4 is offset; bit 5 main rail, bit 6 bridge
// - offset data bit 3 gives sign: one positive, zero negative
// - offset magnitude is five bits of 50 mV added to reference
// - magnitude sits in data bits 4 to 8, bit 4 most significant
// - negative offset acts on main rail only; bridge ignores it
// - main rail target clamped to 2.8 V
// - bridge offset limited to +600 mV over reference
// - code 000 sets overvoltage thresholds in 200 mV steps
// - threshold data: bits 5-6 bridge, bits 7-8 main, rest ignored
// - thresholds reset to +250 mV code for both rails
// - code 001 loads three-bit frequency trim from bits 6-8
// - code 010 loads slope factors, bridge 5-6, main 7-8; reset 1/4
// - code 011 flags: bits 4-5 shedding threshold, reset 00
// - flag bit 6 picks reduced phase count, zero is one phase
// - auto shedding uses the same reduced phase count
// - flag bit 7 enables hint handling, default on; off ignores hint
// - flag bit 8 switches auto phase shedding
// - acknowledge address, command and data; master writes, then stop
// - apply a command only once the stop is seen
// - accept commands only after the output-valid flag is high
// - auto shedding on when bit 8 is one; reset value zero
`timescale 1ns/1ps
`include "pmcd_cfg.svh"

module pmcd_decoder (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        addrStrap,
  input  wire logic        outputValidFlag,
  input  wire logic        lowpowerHintN,
  input  wire logic [11:0] mainRefMv,
  input  wire logic [11:0] bridgeRefMv,
  output logic             mainOffsetSign,
  output logic      [4:0]  mainOffsetMag,
  output logic      [4:0]  bridgeOffsetMag,
  output logic      [12:0] mainTargetMv,
  output logic      [12:0] bridgeTargetMv,
  output logic      [1:0]  mainOvLevel,
  output logic      [1:0]  bridgeOvLevel,
  output logic      [2:0]  freqTrim,
  output logic      [1:0]  mainSlopeFactor,
  output logic      [1:0]  bridgeSlopeFactor,
  output logic      [1:0]  sheddingThresholdSel,
  output logic             lowpowerPhaseCount,
  output logic             lowpowerHintEnable,
  output logic             autoSheddingEnable,
  output logic             reducedPhaseActive,
  output logic             sheddingPhaseCount
);

  // pin synchronisers: scl, sda, strap, valid flag, hint
  localparam int NPIN = 5;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinLvl_q;
  assign pinRaw = {lowpowerHintN, outputValidFlag, addrStrap, sdaIn, sclIn};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gSync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          s1_q <= 1'h1;
          s2_q <= 1'h1;
          s3_q <= 1'h1;
          pinLvl_q[g] <= 1'h1;
        end else begin
          s1_q <= pinRaw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // glitch shorter than a clock never passes
          if (s2_q == s3_q) pinLvl_q[g] <= s3_q;
        end
      end
    end
  endgenerate

  wire sclF      = pinLvl_q[0];
  wire sdaF      = pinLvl_q[1];
  wire strapF    = pinLvl_q[2];
  wire validF    = pinLvl_q[3];
  wire hintNF    = pinLvl_q[4];

  logic sclPrev_q;
  logic sdaPrev_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sclPrev_q <= 1'h1;
      sdaPrev_q <= 1'h1;
    end else begin
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
    end
  end

  wire sclRise = sclF & ~sclPrev_q;
  wire sclFall = ~sclF & sclPrev_q;
  wire startDet = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
  wire stopDet  = sclF & sclPrev_q & ~sdaPrev_q & sdaF;

  // bus registers
  logic ctrlEnable_q;
  logic respond_q;
  logic [31:0] readdata_q;
  logic [7:0] applyCount_q;

  // link engine
  pmcd_pkg::pmcd_state_t state_q;
  pmcd_pkg::pmcd_state_t state_d;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] cmd_q;
  logic [7:0] data_q;
  logic       pend_q;
  logic       ackDrive_q;

  wire [7:0] shiftNext = {shift_q[6:0], sdaF};
  wire lastBit = sclRise & (bitCnt_q == 3'h7);
  wire accept  = validF & ctrlEnable_q;
  // strap low is the default, which answers with bit zero
  wire addrBit = strapF ? ~`PMCD_ADDR_DEFAULT_BIT
                        : `PMCD_ADDR_DEFAULT_BIT;
  wire addrHit = shiftNext == {`PMCD_ADDR_FIXED, addrBit,
                               `PMCD_WRITE_BIT};
  wire inByte  = (state_q == pmcd_pkg::PMCD_ADDR) |
                 (state_q == pmcd_pkg::PMCD_CMD) |
                 (state_q == pmcd_pkg::PMCD_DATA);
  wire inAck   = (state_q == pmcd_pkg::PMCD_ADDR_ACK) |
                 (state_q == pmcd_pkg::PMCD_CMD_ACK) |
                 (state_q == pmcd_pkg::PMCD_DATA_ACK);
  wire ackDone = inAck & sclFall & ackDrive_q;
  wire applyNow = stopDet & pend_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pmcd_pkg::PMCD_IDLE: state_d = state_q;
      pmcd_pkg::PMCD_ADDR: begin
        // foreign address or not ready: stay silent till next start
        if (lastBit) state_d = (addrHit & accept)
                             ? pmcd_pkg::PMCD_ADDR_ACK
                             : pmcd_pkg::PMCD_IDLE;
      end
      pmcd_pkg::PMCD_ADDR_ACK: begin
        if (ackDone) state_d = pmcd_pkg::PMCD_CMD;
      end
      pmcd_pkg::PMCD_CMD: begin
        if (lastBit) state_d = pmcd_pkg::PMCD_CMD_ACK;
      end
      pmcd_pkg::PMCD_CMD_ACK: begin
        if (ackDone) state_d = pmcd_pkg::PMCD_DATA;
      end
      pmcd_pkg::PMCD_DATA: begin
        if (lastBit) state_d = pmcd_pkg::PMCD_DATA_ACK;
      end
      pmcd_pkg::PMCD_DATA_ACK: begin
        if (ackDone) state_d = pmcd_pkg::PMCD_WAIT;
      end
      pmcd_pkg::PMCD_WAIT: state_d = state_q;
      default: state_d = pmcd_pkg::PMCD_IDLE;
    endcase
    if (startDet) state_d = pmcd_pkg::PMCD_ADDR;
    else if (stopDet) state_d = pmcd_pkg::PMCD_IDLE;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) state_q <= pmcd_pkg::PMCD_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bitCnt_q <= 3'h0;
      shift_q  <= 8'h00;
    end else if (startDet | ~inByte) begin
      bitCnt_q <= 3'h0;
    end else if (sclRise) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shift_q  <= shiftNext;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_q  <= 8'h00;
      data_q <= 8'h00;
    end else if (lastBit & (state_q == pmcd_pkg::PMCD_CMD)) begin
      cmd_q  <= shiftNext;
    end else if (lastBit & (state_q == pmcd_pkg::PMCD_DATA)) begin
      data_q <= shiftNext;
    end
  end

  // ack held low from the fall after bit 8 to the fall after the ack clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) ackDrive_q <= 1'h0;
    else if (startDet | stopDet | ~inAck) ackDrive_q <= 1'h0;
    else if (sclFall) ackDrive_q <= ~ackDrive_q;
  end

  // a repeated start or an early stop drops an unfinished command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pend_q <= 1'h0;
    else if (startDet | stopDet) pend_q <= 1'h0;
    else if (ackDone & (state_q == pmcd_pkg::PMCD_DATA_ACK))
      pend_q <= 1'h1;
  end

  assign sdaOut = 1'h0;
  assign sdaOe  = ackDrive_q;

  // command decode
  wire [2:0] cmdCode  = cmd_q[4:2];
  wire isOffset = cmd_q[`PMCD_CMD_OS_BIT];
  wire selMain   = cmd_q[`PMCD_CMD_MAIN];
  wire selBridge = cmd_q[`PMCD_CMD_BRIDGE];
  wire dSign  = data_q[`PMCD_D_SIGN];
  wire [4:0] dMag = data_q[4:0];
  wire [1:0] dHi  = data_q[3:2];
  wire [1:0] dLo  = data_q[1:0];
  wire [2:0] dFsw = data_q[2:0];

  // empty rail selection falls through both enables
  wire doMainOs   = applyNow & isOffset & selMain;
  wire doBridgeOs = applyNow & isOffset & selBridge
                  & dSign;
  wire doOv    = applyNow & ~isOffset
               & (cmdCode == `PMCD_CMD_OV);
  wire doFsw   = applyNow & ~isOffset & (cmdCode == `PMCD_CMD_FSW)
               & (dFsw[1:0] != `PMCD_FSW_SKIP);
  wire doSlope = applyNow & ~isOffset
               & (cmdCode == `PMCD_CMD_SLOPE);
  wire doFlags = applyNow & ~isOffset
               & (cmdCode == `PMCD_CMD_FLAGS);

  // bridge code capped at the +600 mV step
  wire [12:0] bridgeCapCode = 13'(`PMCD_BRIDGE_MAX_MV / `PMCD_OS_STEP_MV);
  wire [4:0] bridgeMagCap = (13'(dMag) > bridgeCapCode)
                          ? bridgeCapCode[4:0] : dMag;

  logic mainSign_q;
  logic [4:0] mainMag_q;
  logic [4:0] bridgeMag_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mainSign_q  <= 1'h1;
      mainMag_q   <= 5'h00;
      bridgeMag_q <= 5'h00;
    end else begin
      if (doMainOs) begin
        mainSign_q <= dSign;
        mainMag_q  <= dMag;
      end
      if (doBridgeOs) bridgeMag_q <= bridgeMagCap;
    end
  end

  logic [1:0] mainOv_q;
  logic [1:0] bridgeOv_q;
  logic [2:0] fsw_q;
  logic [1:0] mainSlope_q;
  logic [1:0] bridgeSlope_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mainOv_q      <= `PMCD_OV_RST;
      bridgeOv_q    <= `PMCD_OV_RST;
      fsw_q         <= `PMCD_FSW_RST;
      mainSlope_q   <= `PMCD_SLOPE_RST;
      bridgeSlope_q <= `PMCD_SLOPE_RST;
    end else begin
      if (doOv) begin
        bridgeOv_q <= dHi;
        mainOv_q   <= dLo;
      end
      if (doFsw) fsw_q <= dFsw;
      // the reserved slope code leaves that rail as it was
      if (doSlope & (dHi != `PMCD_SLOPE_SKIP)) bridgeSlope_q <= dHi;
      if (doSlope & (dLo != `PMCD_SLOPE_SKIP)) mainSlope_q <= dLo;
    end
  end

  logic [1:0] shedTh_q;
  logic phaseCnt_q;
  logic hintEn_q;
  logic shedEn_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shedTh_q   <= `PMCD_SHED_TH_RST;
      phaseCnt_q <= `PMCD_PHASE_RST;
      hintEn_q   <= `PMCD_HINT_EN_RST;
      shedEn_q   <= `PMCD_SHED_EN_RST;
    end else if (doFlags) begin
      shedTh_q   <= data_q[4:3];
      phaseCnt_q <= data_q[`PMCD_D_PHASE];
      hintEn_q   <= data_q[`PMCD_D_HINT_EN];
      shedEn_q   <= data_q[`PMCD_D_SHED_EN];
    end
  end

  // targets follow the references continuously; settings persist
  wire [12:0] mainOffMv   = 13'(mainMag_q * `PMCD_OS_STEP_MV);
  wire [12:0] bridgeOffMv = 13'(bridgeMag_q * `PMCD_OS_STEP_MV);
  wire [12:0] mainRefW    = {1'h0, mainRefMv};
  wire [12:0] mainUp      = mainRefW + mainOffMv;
  wire [12:0] mainDown    = (mainRefW > mainOffMv)
                          ? mainRefW - mainOffMv : 13'h0000;
  wire [12:0] mainRaw     = mainSign_q ? mainUp : mainDown;
  wire [12:0] mainClamp   = (mainRaw > `PMCD_CORE_MAX_MV)
                          ? `PMCD_CORE_MAX_MV : mainRaw;

  logic [12:0] mainTgt_q;
  logic [12:0] bridgeTgt_q;
  logic reduced_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mainTgt_q   <= 13'h0000;
      bridgeTgt_q <= 13'h0000;
      reduced_q   <= 1'h0;
    end else begin
      mainTgt_q   <= mainClamp;
      bridgeTgt_q <= {1'h0, bridgeRefMv} + bridgeOffMv;
      reduced_q   <= hintEn_q & ~hintNF;
    end
  end

  assign mainOffsetSign       = mainSign_q;
  assign mainOffsetMag        = mainMag_q;
  assign bridgeOffsetMag      = bridgeMag_q;
  assign mainTargetMv         = mainTgt_q;
  assign bridgeTargetMv       = bridgeTgt_q;
  assign mainOvLevel          = mainOv_q;
  assign bridgeOvLevel        = bridgeOv_q;
  assign freqTrim             = fsw_q;
  assign mainSlopeFactor      = mainSlope_q;
  assign bridgeSlopeFactor    = bridgeSlope_q;
  assign sheddingThresholdSel = shedTh_q;
  assign lowpowerPhaseCount   = phaseCnt_q;
  assign lowpowerHintEnable   = hintEn_q;
  assign autoSheddingEnable   = shedEn_q;
  assign reducedPhaseActive   = reduced_q;
  assign sheddingPhaseCount   = phaseCnt_q;

  // Avalon slave: one wait cycle, read data latched while waiting
  wire busReq  = read | write;
  wire selCtrl = address == `PMCD_REG_CTRL;
  wire selOff  = address == `PMCD_REG_OFFSET;
  wire selSet  = address == `PMCD_REG_SETTING;
  wire selStat = address == `PMCD_REG_STATUS;
  wire [31:0] rdCtrl = {31'h0, ctrlEnable_q};
  wire [31:0] rdOff  = {19'h0, bridgeMag_q, 2'h0, mainSign_q, mainMag_q};
  wire [31:0] rdSet  = {16'h0, shedEn_q, hintEn_q, phaseCnt_q, shedTh_q,
                        bridgeSlope_q, mainSlope_q, fsw_q, bridgeOv_q,
                        mainOv_q};
  wire [31:0] rdStat = {16'h0, applyCount_q, 1'h0, cmdCode, pend_q,
                        strapF, validF,
                        (state_q != pmcd_pkg::PMCD_IDLE)};
  wire [31:0] rdMux  = selCtrl ? rdCtrl
                     : selOff ? rdOff
                     : selSet ? rdSet
                     : selStat ? rdStat : 32'h00000000;

  assign waitrequest = busReq & ~respond_q;
  assign readdata    = readdata_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      respond_q  <= 1'h0;
      readdata_q <= 32'h00000000;
    end else begin
      respond_q <= busReq & ~respond_q;
      if (read & ~respond_q) readdata_q <= rdMux;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) ctrlEnable_q <= `PMCD_CTRL_RST;
    else if (write & respond_q & selCtrl) ctrlEnable_q <= writedata[0];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) applyCount_q <= 8'h00;
    else if (applyNow) applyCount_q <= applyCount_q + 8'h01;
  end

endmodule

// file: verification/pmcd_decoder_assertions.sv
// concurrent checks on the decoder's pins
// assumes binding to pmcd_decoder, one clock domain
`timescale 1ns/1ps
module pmcd_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        outputValidFlag,
  input wire logic [11:0] mainRefMv,
  input wire logic [11:0] bridgeRefMv,
  input wire logic        mainOffsetSign,
  input wire logic [4:0]  mainOffsetMag,
  input wire logic [4:0]  bridgeOffsetMag,
  input wire logic [12:0] mainTargetMv,
  input wire logic [12:0] bridgeTargetMv,
  input wire logic [1:0]  mainOvLevel,
  input wire logic [1:0]  bridgeOvLevel,
  input wire logic [2:0]  freqTrim,
  input wire logic [1:0]  mainSlopeFactor,
  input wire logic [1:0]  bridgeSlopeFactor,
  input wire logic [1:0]  sheddingThresholdSel,
  input wire logic        lowpowerPhaseCount,
  input wire logic        lowpowerHintEnable,
  input wire logic        autoSheddingEnable,
  input wire logic        reducedPhaseActive,
  input wire logic        sheddingPhaseCount
);
  logic [13:0] mainUp;
  logic [13:0] mainDn;
  logic [12:0] expMain;
  logic [12:0] expBridge;
  logic [15:0] cfgBits;
  logic [10:0] offBits;
  logic [3:0]  sinceStop_q;
  logic        sdaPrev_q;
  assign mainUp = {2'h0, mainRefMv} + 14'(mainOffsetMag) * 14'h0032;
  assign mainDn = 14'(mainOffsetMag) * 14'h0032;
  // negative offsets floor at zero, positive ones stop at the ceiling
  assign expMain = mainOffsetSign
    ? ((mainUp > 14'h0AF0) ? 13'h0AF0 : mainUp[12:0])
    : ((mainDn > 14'(mainRefMv)) ? 13'h0000 : 13'(14'(mainRefMv) - mainDn));
  assign expBridge = 13'(bridgeRefMv) + 13'(bridgeOffsetMag) * 13'h0032;
  assign cfgBits = {mainOvLevel, bridgeOvLevel, freqTrim, mainSlopeFactor,
    bridgeSlopeFactor, sheddingThresholdSel, lowpowerPhaseCount,
    lowpowerHintEnable, autoSheddingEnable};
  assign offBits = {mainOffsetSign, mainOffsetMag, bridgeOffsetMag};
  // cycles since the raw pins last showed a stop, saturating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sdaPrev_q <= 1'b1;
      sinceStop_q <= 4'hF;
    end else begin
      sdaPrev_q <= sdaIn;
      if (sclIn && sdaIn && !sdaPrev_q) sinceStop_q <= 4'h0;
      else if (sinceStop_q != 4'hF) sinceStop_q <= sinceStop_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=>
    !waitrequest) else $error("bus answer late");
  AST_MAIN_TARGET: assert property (
    $past(nrst) |-> mainTargetMv == $past(expMain))
    else $error("main target wrong");
  AST_BRIDGE_TARGET: assert property (
    $past(nrst) |-> bridgeTargetMv == $past(expBridge))
    else $error("bridge target wrong");
  AST_BRIDGE_LIMIT: assert property (bridgeOffsetMag <= 5'h0C)
    else $error("bridge offset above limit");
  AST_RESET_VALUES: assert property (
    $rose(nrst) |-> cfgBits == 16'h0002 && offBits[9:0] == 10'h000)
    else $error("settings not at reset values");
  AST_SHED_PHASE: assert property (
    sheddingPhaseCount == lowpowerPhaseCount)
    else $error("shedding phase count differs");
  AST_HINT_GATE: assert property (
    !lowpowerHintEnable |=> !reducedPhaseActive)
    else $error("hint acted while disabled");
  AST_APPLY_AT_STOP: assert property (
    $changed(cfgBits) || $changed(offBits) |-> sinceStop_q <= 4'hC)
    else $error("setting changed away from a stop");
  AST_NO_ACK_INVALID: assert property (
    (!outputValidFlag)[*8] |-> !$rose(sdaOe))
    else $error("acknowledge before output valid");
  AST_ACK_SHAPE: assert property (
    $rose(sdaOe) |-> (sdaOe && !sdaOut)[*6] ##[1:6] !sdaOe)
    else $error("acknowledge pulse malformed");
  cover property ($fell(sdaOe));
  cover property ($rose(autoSheddingEnable));
  cover property (bridgeOffsetMag == 5'h0C);
endmodule

// file: verification/pmcd_i2c_master.sv
// serial bus master for the decoder's write port
// assumes a pulled-up data line; the device pulls low through sdaOe
`timescale 1ns/1ps
module pmcd_i2c_master (
  input  wire logic clock,
  input  wire logic sdaOe,
  output logic      sclIn,
  output logic      sdaIn
);
  logic sclDrv;
  logic sdaDrv;
  assign sclIn = sclDrv;
  assign sdaIn = sdaDrv & ~sdaOe;
  // clock stands high between frames
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // 400 ns bit: data moves late in the low phase, one clock before the device's ack release
  task automatic sendBit(input logic b, output logic seen);
    waitClk(4);
    sdaDrv <= b;
    waitClk(1);
    sclDrv <= 1'b1;
    waitClk(3);
    seen = sdaIn;
    sclDrv <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] a, c, d, output logic [2:0] ack);
    logic [23:0] w;
    logic        s;
    w = {a, c, d};
    sdaDrv <= 1'b0;
    waitClk(4);
    sclDrv <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sendBit(w[i], s);
      if (i % 8 == 0) begin
        sendBit(1'b1, s);
        ack[i / 8] = ~s;
      end
    end
    waitClk(4);
    sdaDrv <= 1'b0;
    waitClk(1);
    sclDrv <= 1'b1;
    waitClk(4);
    sdaDrv <= 1'b1;
    waitClk(8);
  endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench: bus tasks and serial write frames
// assumes pmcd_decoder with the serial master model on its link pins
`timescale 1ns/1ps
module tb_top;
  logic        clock, nrst, read, write, waitrequest;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic        sclIn, sdaIn, sdaOut, sdaOe, addrStrap;
  logic        outputValidFlag, lowpowerHintN, mainOffsetSign;
  logic [11:0] mainRefMv, bridgeRefMv;
  logic [4:0]  mainOffsetMag, bridgeOffsetMag;
  logic [12:0] mainTargetMv, bridgeTargetMv;
  logic [1:0]  mainOvLevel, bridgeOvLevel, mainSlopeFactor;
  logic [1:0]  bridgeSlopeFactor, sheddingThresholdSel, expB, expM;
  logic [2:0]  freqTrim, expF;
  logic        lowpowerPhaseCount, lowpowerHintEnable;
  logic        autoSheddingEnable, reducedPhaseActive, sheddingPhaseCount;
  logic [15:0] cfg;
  int          failCount, numChecks, cycles;
  logic [7:0]  offCmd [5] = '{8'hF8, 8'h1C, 8'h1C, 8'hF0, 8'h14};
  logic [7:0]  offDat [5] = '{8'hE5, 8'h3F, 8'h04, 8'h21, 8'h23};
  logic [15:0] offExp [5] = '{16'h04A0, 16'h07EC, 16'h008C, 16'h008C,
    16'h0083};
  logic [15:0] mainExp [5] = '{16'h06D6, 16'h0AF0, 16'h0514, 16'h0514,
    16'h0514};
  logic [15:0] brExp [5] = '{16'h044C, 16'h06A4, 16'h06A4, 16'h06A4,
    16'h04E2};
  assign cfg = {mainOvLevel, bridgeOvLevel, freqTrim, mainSlopeFactor,
    bridgeSlopeFactor, sheddingThresholdSel, lowpowerPhaseCount,
    lowpowerHintEnable, autoSheddingEnable};
  pmcd_decoder dut (.*);
  pmcd_i2c_master link (.clock(clock), .sdaOe(sdaOe), .sclIn(sclIn),
    .sdaIn(sdaIn));
  always #25 clock = ~clock;
  task automatic check(input logic [15:0] got, exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic busDo(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic send(input logic [7:0] a, c, d, input logic [2:0] exp);
    logic [2:0] ack;
    link.frame(a, c, d, ack);
    check(16'(ack), 16'(exp));
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      endOfTest();
    end
  end
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    {read, write, address, writedata} = '0;
    {addrStrap, lowpowerHintN, outputValidFlag} = 3'b011;
    mainRefMv = 12'h3E8;
    bridgeRefMv = 12'h44C;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    check(cfg, 16'h0002);
    check(16'(mainTargetMv), 16'h03E8);
    busDo(1'b0, 4'h0, 32'h0);
    check(rd[15:0], 16'h0001);
    busDo(1'b0, 4'h2, 32'h0);
    check(rd[15:0], 16'h0000);
    busDo(1'b1, 4'h8, 32'hFFFF_FFFF);
    busDo(1'b0, 4'h8, 32'h0);
    check(rd[15:0], 16'h4000);
    $display("reset and bus test done");
    outputValidFlag <= 1'b0;
    repeat (8) @(posedge clock);
    send(8'hCC, 8'h00, 8'h0F, 3'b000);
    outputValidFlag <= 1'b1;
    send(8'hCE, 8'h00, 8'h0F, 3'b000);
    send(8'hCD, 8'h00, 8'h0F, 3'b000);
    busDo(1'b1, 4'h0, 32'h0);
    send(8'hCC, 8'h00, 8'h0F, 3'b000);
    busDo(1'b1, 4'h0, 32'h1);
    check(cfg, 16'h0002);
    addrStrap <= 1'b1;
    send(8'hCE, 8'hE3, 8'hF6, 3'b111);
    check(cfg, 16'h9002);
    addrStrap <= 1'b0;
    send(8'hCC, 8'h00, 8'h0F, 3'b111);
    check(cfg, 16'hF002);
    $display("address and threshold test done");
    expF = 3'h0;
    for (int k = 0; k < 8; k++) begin
      send(8'hCC, 8'hE7, {5'h1F, 3'(k)}, 3'b111);
      if (k % 4 != 3) expF = 3'(k);
      check(16'(freqTrim), 16'(expF));
    end
    {expB, expM} = 4'h0;
    for (int k = 0; k < 4; k++) begin
      send(8'hCC, 8'hEB, {4'hF, 2'(k), 2'(3 - k)}, 3'b111);
      if (k != 2) expB = 2'(k);
      if (k != 1) expM = 2'(3 - k);
      check({mainSlopeFactor, bridgeSlopeFactor}, 16'({expM, expB}));
    end
    $display("trim and slope test done");
    lowpowerHintN <= 1'b0;
    send(8'hCC, 8'hEC, 8'hE5, 3'b111);
    check(16'(cfg[4:0]), 16'h0005);
    check(16'({reducedPhaseActive, sheddingPhaseCount}), 16'h0001);
    send(8'hCC, 8'hEC, 8'h1A, 3'b111);
    check(16'(cfg[4:0]), 16'h001A);
    check(16'(reducedPhaseActive), 16'h0001);
    lowpowerHintN <= 1'b1;
    repeat (8) @(posedge clock);
    check(16'(reducedPhaseActive), 16'h0000);
    $display("flags test done");
    mainRefMv <= 12'h5DC;
    for (int k = 0; k < 5; k++) begin
      send(8'hCC, offCmd[k], offDat[k], 3'b111);
      check(16'({mainOffsetSign, mainOffsetMag, bridgeOffsetMag}), offExp[k]);
      check(16'(mainTargetMv), mainExp[k]);
      check(16'(bridgeTargetMv), brExp[k]);
    end
    busDo(1'b0, 4'h4, 32'h0);
    check(rd[15:0], 16'h0304);
    check(cfg, 16'hFC7A);
    $display("offset test done");
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    check(cfg, 16'h0002);
    $display("second reset test done");
    endOfTest();
  end
endmodule
bind pmcd_decoder pmcd_chk chk (.*);
